// ===== cts_pkg.sv
// Purpose: Shared constants and types for the cascaded 16-bit timer
// Assumes: 25 MHz system clock drives the register bus and the timer
// Notes:   Registers except status are 8 bits wide and sit in the low byte of a word
package cts_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTS_OFF_LOW_CTRL = 8'h00;
  localparam logic [7:0] CTS_OFF_HIGH_CTRL = 8'h04;
  localparam logic [7:0] CTS_OFF_PER_LOW = 8'h08;
  localparam logic [7:0] CTS_OFF_PER_HIGH = 8'h0C;
  localparam logic [7:0] CTS_OFF_WID_LOW = 8'h10;
  localparam logic [7:0] CTS_OFF_WID_HIGH = 8'h14;
  localparam logic [7:0] CTS_OFF_STATUS = 8'h18;

  localparam logic [7:0] CTS_RST_CTRL = 8'h00;
  localparam logic [7:0] CTS_RST_CMP = 8'h00;

  // ----------------------------------------------------------------
  // Mode and clock encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CTS_MODE_PPG = 3'h7;
  localparam logic [2:0] CTS_MODE_WARM = 3'h5;
  localparam logic [2:0] CTS_CLK_EXT = 3'h7;

  // Status word field positions
  localparam int CTS_ST_TOGGLE_POS = 16;
  localparam int CTS_ST_RUN_POS = 17;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CTS_CLK_HZ = 25_000_000;
  localparam int CTS_LF_HZ = 32_768;
  localparam int CTS_LF_DIV = CTS_CLK_HZ / CTS_LF_HZ;
  localparam logic [9:0] CTS_LF_LAST = 10'(CTS_LF_DIV - 1);

  localparam logic [1:0] CTS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CTS_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic toggle_preset_low;
    logic [2:0] clk_sel;
    logic spare;
    logic [2:0] mode;
  } cts_low_ctrl_t;

  typedef struct packed {
    logic toggle_preset_high;
    logic [2:0] mode_hi;
    logic run_control;
    logic [2:0] mode;
  } cts_high_ctrl_t;

  // Register index decoded from a bus address
  typedef enum logic [2:0] {
    CTS_R_LOW_CTRL = 3'd0,
    CTS_R_HIGH_CTRL = 3'd1,
    CTS_R_PER_LOW = 3'd2,
    CTS_R_PER_HIGH = 3'd3,
    CTS_R_WID_LOW = 3'd4,
    CTS_R_WID_HIGH = 3'd5,
    CTS_R_STATUS = 3'd6,
    CTS_R_NONE = 3'd7
  } cts_reg_t;

  // Write channel states, Gray from WAIT through EXEC to RESP
  typedef enum logic [1:0] {
    CTS_W_WAIT = 2'b00,
    CTS_W_EXEC = 2'b01,
    CTS_W_RESP = 2'b11
  } cts_wst_t;

endpackage

// ===== cts_prescale.sv
// Purpose: Free-running divider giving one-cycle clock enables
// Assumes: mclk_in stands for the high-frequency clock
// Notes:   Index of tick_out equals the clock select code
`timescale 1ns/10ps
`default_nettype none
module cts_prescale
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Enables, one per internal clock select code
  output logic [6:0] tick_out
);

  logic [10:0] div_r;
  logic [10:0] div_nxt;
  logic [9:0] lf_r;
  logic [9:0] lf_nxt;
  logic [6:0] tick_nxt;

  always_comb
  begin
    div_nxt = div_r + 11'h001;
    lf_nxt = (lf_r == CTS_LF_LAST) ? 10'h000 : lf_r + 10'h001;
    tick_nxt[0] = &div_r[10:0];
    tick_nxt[1] = &div_r[6:0];
    tick_nxt[2] = &div_r[4:0];
    tick_nxt[3] = &div_r[2:0];
    // Low-frequency clock approximated by an integer divide
    tick_nxt[4] = (lf_r == CTS_LF_LAST);
    tick_nxt[5] = div_r[0];
    tick_nxt[6] = 1'b1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_r <= 11'h000;
      lf_r <= 10'h000;
      tick_out <= 7'h00;
    end
    else
    begin
      div_r <= div_nxt;
      lf_r <= lf_nxt;
      tick_out <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== cts_sync.sv
// Purpose: Two-flop synchroniser for the external count pin
// Assumes: Pin level is asynchronous to mclk_in
// Notes:   Only the second flop is visible outside
`timescale 1ns/10ps
`default_nettype none
module cts_sync
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Pin
  input wire logic pin_in,
  output logic pin_sync_out
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync_out = sync_r;

endmodule
`default_nettype wire

// ===== cts_timer.sv
// Purpose: Cascaded 16-bit timer with pulse generator and warm-up modes
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   Other cascade modes are decoded but leave the counter idle
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R1] Two stages count as one 16-bit up-counter
// [R2] Width match inverts toggle, counter keeps running
// [R3] Period match inverts toggle, clears, raises request
// [R4] External clock high/low at least two cycles
// [R5] Preset bit loads toggle; reset clears it
// [R6] Pulse pin is inverse of toggle
// [R7] Software writes low byte, then high byte
// [R8] Software sets shared port latch to one
// [R9] Compare registers take effect immediately
// [R10] Stopping holds pin; preset only after stop
// [R11] Bit 3 runs; clearing bit 7 stopped forces high
// [R12] 57h selects pulse mode, 5Fh also starts
// [R13] Warm-up mode cascades stages as 16-bit timer
// [R14] Software keeps preset bits zero in warm-up
// [R15] Warm-up compares only upper period byte
// [R16] Warm-up match clears counter and raises request
// [R17] Software enables slow oscillator before starting
// [R18] Software stops, selects slow clock, stops fast
// [R19] Software mirrors sequence for slow-to-fast switch
// [R20] Warm-up period spans 0100h to FF00h
// [R21] 05h warm-up; 43h slow, 63h fast source
// [R22] Request is one-cycle pulse with the clear
module cts_timer
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Timer pins
  input wire logic ext_count_pin_in,
  output logic pulse_out_n_out,
  output logic timer_match_irq_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic cts_reg_t cts_decode(input logic [7:0] addr);
    cts_reg_t idx;
    begin
      unique case (addr)
        CTS_OFF_LOW_CTRL: idx = CTS_R_LOW_CTRL;
        CTS_OFF_HIGH_CTRL: idx = CTS_R_HIGH_CTRL;
        CTS_OFF_PER_LOW: idx = CTS_R_PER_LOW;
        CTS_OFF_PER_HIGH: idx = CTS_R_PER_HIGH;
        CTS_OFF_WID_LOW: idx = CTS_R_WID_LOW;
        CTS_OFF_WID_HIGH: idx = CTS_R_WID_HIGH;
        CTS_OFF_STATUS: idx = CTS_R_STATUS;
        default: idx = CTS_R_NONE;
      endcase
      return idx;
    end
  endfunction

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  logic [6:0] tick_vec;
  logic pin_sync;
  logic pin_prev_r;

  cts_prescale u_prescale (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick_vec)
  );

  cts_sync u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in(ext_count_pin_in),
    .pin_sync_out(pin_sync)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin_sync;
    end
  end

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  cts_wst_t wst_r;
  cts_wst_t wst_nxt;
  logic aw_got_r;
  logic aw_got_nxt;
  logic w_got_r;
  logic w_got_nxt;
  logic [7:0] awaddr_r;
  logic [7:0] awaddr_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic wstrb_r;
  logic wstrb_nxt;
  logic awready_nxt;
  logic wready_nxt;
  logic bvalid_nxt;
  logic [1:0] bresp_nxt;
  logic wr_exec;
  cts_reg_t wr_idx;

  assign wr_exec = (wst_r == CTS_W_EXEC);
  assign wr_idx = cts_decode(awaddr_r);

  // Address and data may arrive in either order or together
  always_comb
  begin
    wst_nxt = wst_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = s_axi_bvalid_out;
    bresp_nxt = s_axi_bresp_out;
    unique case (wst_r)
      CTS_W_WAIT:
      begin
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
          aw_got_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
          w_got_nxt = 1'b1;
          wdata_nxt = s_axi_wdata_in[7:0];
          wstrb_nxt = s_axi_wstrb_in[0];
        end
        if (aw_got_nxt && w_got_nxt)
        begin
          wst_nxt = CTS_W_EXEC;
        end
      end
      CTS_W_EXEC:
      begin
        bvalid_nxt = 1'b1;
        bresp_nxt = (wr_idx == CTS_R_NONE) ? CTS_RESP_SLVERR
                                           : CTS_RESP_OKAY;
        wst_nxt = CTS_W_RESP;
      end
      CTS_W_RESP:
      begin
        if (s_axi_bready_in)
        begin
          bvalid_nxt = 1'b0;
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          wst_nxt = CTS_W_WAIT;
        end
      end
      default:
      begin
        wst_nxt = CTS_W_WAIT;
      end
    endcase
    awready_nxt = (wst_nxt == CTS_W_WAIT) && !aw_got_nxt;
    wready_nxt = (wst_nxt == CTS_W_WAIT) && !w_got_nxt;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wst_r <= CTS_W_WAIT;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= CTS_RESP_OKAY;
    end
    else
    begin
      wst_r <= wst_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready_out <= awready_nxt;
      s_axi_wready_out <= wready_nxt;
      s_axi_bvalid_out <= bvalid_nxt;
      s_axi_bresp_out <= bresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers and counter
  // ----------------------------------------------------------------
  cts_low_ctrl_t low_stage_ctrl_r;
  cts_low_ctrl_t low_stage_ctrl_nxt;
  cts_high_ctrl_t high_stage_ctrl_r;
  cts_high_ctrl_t high_stage_ctrl_nxt;
  cts_high_ctrl_t hc_wr;
  logic [7:0] period_cmp_low_r;
  logic [7:0] period_cmp_low_nxt;
  logic [7:0] period_cmp_high_r;
  logic [7:0] period_cmp_high_nxt;
  logic [7:0] width_cmp_low_r;
  logic [7:0] width_cmp_low_nxt;
  logic [7:0] width_cmp_high_r;
  logic [7:0] width_cmp_high_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] count_inc;
  logic toggle_flop_r;
  logic toggle_flop_nxt;
  logic irq_nxt;
  logic run;
  logic tick;
  logic wr_en;

  assign run = high_stage_ctrl_r.run_control; // see [R11]
  assign count_inc = count_r + 16'h0001;
  assign wr_en = wr_exec && wstrb_r;
  assign hc_wr = cts_high_ctrl_t'(wdata_r);

  // Source select lives in the low stage; pin counts falling edges
  always_comb
  begin
    if (low_stage_ctrl_r.clk_sel == CTS_CLK_EXT)
    begin
      tick = pin_prev_r && !pin_sync; // see [R4]
    end
    else
    begin
      tick = tick_vec[low_stage_ctrl_r.clk_sel];
    end
  end

  always_comb
  begin
    low_stage_ctrl_nxt = low_stage_ctrl_r;
    high_stage_ctrl_nxt = high_stage_ctrl_r;
    period_cmp_low_nxt = period_cmp_low_r;
    period_cmp_high_nxt = period_cmp_high_r;
    width_cmp_low_nxt = width_cmp_low_r;
    width_cmp_high_nxt = width_cmp_high_r;
    count_nxt = count_r;
    toggle_flop_nxt = toggle_flop_r;
    irq_nxt = 1'b0;
    // Compare values are used as written, no shadow copy
    if (wr_en)
    begin
      unique case (wr_idx)
        CTS_R_LOW_CTRL: low_stage_ctrl_nxt = cts_low_ctrl_t'(wdata_r);
        CTS_R_HIGH_CTRL: high_stage_ctrl_nxt = hc_wr; // see [R12] [R21]
        CTS_R_PER_LOW: period_cmp_low_nxt = wdata_r; // see [R9]
        CTS_R_PER_HIGH: period_cmp_high_nxt = wdata_r;
        CTS_R_WID_LOW: width_cmp_low_nxt = wdata_r;
        CTS_R_WID_HIGH: width_cmp_high_nxt = wdata_r;
        default:
        begin
        end
      endcase
    end
    if (!run)
    begin
      // A stopped counter restarts from zero
      count_nxt = 16'h0000;
    end
    else if (tick)
    begin
      if (high_stage_ctrl_r.mode == CTS_MODE_PPG)
      begin
        if (count_inc == {period_cmp_high_r, period_cmp_low_r})
        begin
          count_nxt = 16'h0000; // see [R3]
          toggle_flop_nxt = !toggle_flop_r;
          irq_nxt = 1'b1; // see [R22]
        end
        else if (count_inc == {width_cmp_high_r, width_cmp_low_r})
        begin
          count_nxt = count_inc; // see [R2]
          toggle_flop_nxt = !toggle_flop_r;
        end
        else
        begin
          count_nxt = count_inc; // see [R1]
        end
      end
      else if (high_stage_ctrl_r.mode == CTS_MODE_WARM)
      begin
        // Low period byte ignored, so the step is 256 counts
        if (count_inc[15:8] == period_cmp_high_r) // see [R15] [R20]
        begin
          count_nxt = 16'h0000; // see [R16]
          irq_nxt = 1'b1; // see [R22]
        end
        else
        begin
          count_nxt = count_inc; // see [R13]
        end
      end
    end
    // Preset only from a stopped timer; a stopping write keeps level
    if (wr_en && (wr_idx == CTS_R_HIGH_CTRL) && !run && !hc_wr.run_control)
    begin
      toggle_flop_nxt = hc_wr.toggle_preset_high; // see [R5] [R10] [R11]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_stage_ctrl_r <= cts_low_ctrl_t'(CTS_RST_CTRL);
      high_stage_ctrl_r <= cts_high_ctrl_t'(CTS_RST_CTRL);
      period_cmp_low_r <= CTS_RST_CMP;
      period_cmp_high_r <= CTS_RST_CMP;
      width_cmp_low_r <= CTS_RST_CMP;
      width_cmp_high_r <= CTS_RST_CMP;
      count_r <= 16'h0000;
      toggle_flop_r <= 1'b0; // see [R5]
      pulse_out_n_out <= 1'b1;
      timer_match_irq_out <= 1'b0;
    end
    else
    begin
      low_stage_ctrl_r <= low_stage_ctrl_nxt;
      high_stage_ctrl_r <= high_stage_ctrl_nxt;
      period_cmp_low_r <= period_cmp_low_nxt;
      period_cmp_high_r <= period_cmp_high_nxt;
      width_cmp_low_r <= width_cmp_low_nxt;
      width_cmp_high_r <= width_cmp_high_nxt;
      count_r <= count_nxt;
      toggle_flop_r <= toggle_flop_nxt;
      pulse_out_n_out <= !toggle_flop_nxt; // see [R6]
      timer_match_irq_out <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  logic arready_nxt;
  logic rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[15:0] = count_r;
    status_word[CTS_ST_TOGGLE_POS] = toggle_flop_r;
    status_word[CTS_ST_RUN_POS] = run;
  end

  always_comb
  begin
    rvalid_nxt = s_axi_rvalid_out;
    rdata_nxt = s_axi_rdata_out;
    rresp_nxt = s_axi_rresp_out;
    if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = CTS_RESP_OKAY;
      unique case (cts_decode(s_axi_araddr_in))
        CTS_R_LOW_CTRL: rdata_nxt = {24'h00_0000, low_stage_ctrl_r};
        CTS_R_HIGH_CTRL: rdata_nxt = {24'h00_0000, high_stage_ctrl_r};
        CTS_R_PER_LOW: rdata_nxt = {24'h00_0000, period_cmp_low_r};
        CTS_R_PER_HIGH: rdata_nxt = {24'h00_0000, period_cmp_high_r};
        CTS_R_WID_LOW: rdata_nxt = {24'h00_0000, width_cmp_low_r};
        CTS_R_WID_HIGH: rdata_nxt = {24'h00_0000, width_cmp_high_r};
        CTS_R_STATUS: rdata_nxt = status_word;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = CTS_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= CTS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready_out <= arready_nxt;
      s_axi_rvalid_out <= rvalid_nxt;
      s_axi_rdata_out <= rdata_nxt;
      s_axi_rresp_out <= rresp_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== cts_timer_chk.sv
// Purpose: Bus and timer output checks for cts_timer
// Assumes: One clock, active-low asynchronous reset
// Notes:   Sees only the top module's ports
`timescale 1ns/10ps
`default_nettype none
module cts_timer_chk
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Timer pins
  input wire logic pulse_out_n_out,
  input wire logic timer_match_irq_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  irq_one_cycle_a: assert property (
    timer_match_irq_out |=> !timer_match_irq_out)
    else $error("match request longer than one cycle");
  reset_level_a: assert property (
    $rose(rst_n_in) |-> pulse_out_n_out && !timer_match_irq_out)
    else $error("pins not idle after reset");
  aw_drop_a: assert property (
    s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
    else $error("write address ready stayed high");
  w_answer_a: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write response not two edges later");
  b_stand_a: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  b_reopen_a: assert property (
    s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out ##1 (s_axi_awready_out && s_axi_wready_out))
    else $error("write channel not reopened");
  r_latency_a: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer not one edge later");
  r_stand_a: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  r_reopen_a: assert property (
    s_axi_rvalid_out && s_axi_rready_in |=>
    !s_axi_rvalid_out ##1 s_axi_arready_out)
    else $error("read channel not reopened");
endmodule

bind cts_timer cts_timer_chk u_cts_timer_chk (.*);
`default_nettype wire

// ===== test_cascaded_timer_ppg_warmup.sv
// Purpose: Self-checking bench for cts_timer
// Assumes: 25 MHz clock, bus master waits for every answer
// Notes:   Every-cycle tick select keeps timer runs short
`timescale 1ns/10ps
`default_nettype none
module test_cascaded_timer_ppg_warmup
  import cts_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00;
  logic s_axi_awvalid_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_in = 4'h1;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic [7:0] s_axi_araddr_in = 8'h00;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic ext_count_pin_in = 1'b1;
  logic s_axi_awready_out;
  logic s_axi_wready_out;
  logic [1:0] s_axi_bresp_out;
  logic s_axi_bvalid_out;
  logic s_axi_arready_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0] s_axi_rresp_out;
  logic s_axi_rvalid_out;
  logic pulse_out_n_out;
  logic timer_match_irq_out;
  int errors = 0;
  int checks = 0;

  cts_timer dut (.*);

  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    errors++;
    report_and_stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      n++;
      if (s_axi_awready_out)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out)
        s_axi_wvalid_in <= 1'b0;
    end
    while (!s_axi_bvalid_out && n < 50);
    if (n >= 50)
      hang();
    check(s_axi_bresp_out, er);
    s_axi_bready_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      n++;
      if (s_axi_arready_out)
        s_axi_arvalid_in <= 1'b0;
    end
    while (!s_axi_rvalid_out && n < 50);
    if (n >= 50)
      hang();
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // Compare halves go low byte first, never one alone
  task automatic wr_cmp(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0], CTS_RESP_OKAY);
    wr(a + 8'h04, v[15:8], CTS_RESP_OKAY);
  endtask

  task automatic chk_stat(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(CTS_OFF_STATUS, d, r);
    check(d, exp);
    check(r, CTS_RESP_OKAY);
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      @(posedge mclk_in);
      #1;
      c++;
    end
    while (timer_match_irq_out !== 1'b1 && c < 5000);
    if (c >= 5000)
      hang();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    int i;
    check(pulse_out_n_out, 1'b1);
    check(timer_match_irq_out, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      rd(8'(4 * i), d, r);
      check(d, 32'h0000_0000);
      check(r, CTS_RESP_OKAY);
    end
    chk_stat(32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
    wr_cmp(CTS_OFF_PER_LOW, 16'h3CA5);
    rd(CTS_OFF_PER_LOW, d, r);
    check(d, 32'h0000_00A5);
    rd(CTS_OFF_PER_HIGH, d, r);
    check(d, 32'h0000_003C);
    rd(8'h1C, d, r);
    check(d, 32'h0000_0000);
    check(r, CTS_RESP_SLVERR);
    wr(8'h20, 8'h55, CTS_RESP_SLVERR);
    wr(CTS_OFF_STATUS, 8'hFF, CTS_RESP_OKAY);
    chk_stat(32'h0000_0000);
    $display("test registers done");
  endtask

  // Period 5, width 2, preset p: one full cycle tick by tick
  task automatic test_ppg(input logic p);
    int k;
    int c;
    wr(CTS_OFF_LOW_CTRL, 8'h63, CTS_RESP_OKAY);
    wr_cmp(CTS_OFF_PER_LOW, 16'h0005);
    wr_cmp(CTS_OFF_WID_LOW, 16'h0002);
    wr(CTS_OFF_HIGH_CTRL, {p, 7'h57}, CTS_RESP_OKAY);
    #1;
    check(pulse_out_n_out, !p);
    wr(CTS_OFF_HIGH_CTRL, {p, 7'h5F}, CTS_RESP_OKAY);
    wait_irq(c);
    for (k = 1; k <= 5; k++)
    begin
      @(posedge mclk_in);
      #1;
      check(pulse_out_n_out, !(p ^ (k >= 2 && k < 5)));
      check(timer_match_irq_out, k == 5);
    end
    wr(CTS_OFF_HIGH_CTRL, {p, 7'h57}, CTS_RESP_OKAY);
    $display("test pulse generator done");
  endtask

  task automatic test_hold;
    int c;
    wr_cmp(CTS_OFF_PER_LOW, 16'h0100);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    wr(CTS_OFF_HIGH_CTRL, 8'h5F, CTS_RESP_OKAY);
    wait_irq(c);
    repeat (4) @(posedge mclk_in);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    repeat (20) @(posedge mclk_in);
    #1;
    check(pulse_out_n_out, 1'b0);
    chk_stat(32'h0001_0000);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    #1;
    check(pulse_out_n_out, 1'b1);
    chk_stat(32'h0000_0000);
    $display("test stop hold done");
  endtask

  // Low byte of the period is all ones and must not matter
  task automatic test_warm;
    int i;
    int c;
    wr(CTS_OFF_LOW_CTRL, 8'h63, CTS_RESP_OKAY);
    wr(CTS_OFF_HIGH_CTRL, 8'h05, CTS_RESP_OKAY);
    for (i = 1; i <= 2; i++)
    begin
      wr_cmp(CTS_OFF_PER_LOW, {8'(i), 8'hFF});
      wr(CTS_OFF_HIGH_CTRL, 8'h0D, CTS_RESP_OKAY);
      wait_irq(c);
      wait_irq(c);
      check(c, 256 * i);
      check(pulse_out_n_out, 1'b1);
      wr(CTS_OFF_HIGH_CTRL, 8'h05, CTS_RESP_OKAY);
    end
    $display("test warm-up done");
  endtask

  task automatic test_ext;
    int i;
    wr(CTS_OFF_LOW_CTRL, 8'h73, CTS_RESP_OKAY);
    wr_cmp(CTS_OFF_PER_LOW, 16'hFFFF);
    wr_cmp(CTS_OFF_WID_LOW, 16'hFFFF);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    wr(CTS_OFF_HIGH_CTRL, 8'h5F, CTS_RESP_OKAY);
    for (i = 0; i < 6; i++)
    begin
      repeat (4) @(posedge mclk_in);
      ext_count_pin_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      ext_count_pin_in <= 1'b1;
    end
    repeat (8) @(posedge mclk_in);
    chk_stat(32'h0002_0006);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    $display("test external clock done");
  endtask

  // Period 2: two source ticks between requests
  task automatic test_clk;
    int c;
    wr_cmp(CTS_OFF_PER_LOW, 16'h0002);
    wr(CTS_OFF_LOW_CTRL, 8'h33, CTS_RESP_OKAY);
    wr(CTS_OFF_HIGH_CTRL, 8'h5F, CTS_RESP_OKAY);
    wait_irq(c);
    wait_irq(c);
    check(c, 16);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    wr(CTS_OFF_LOW_CTRL, 8'h43, CTS_RESP_OKAY);
    wr(CTS_OFF_HIGH_CTRL, 8'h5F, CTS_RESP_OKAY);
    wait_irq(c);
    wait_irq(c);
    check(c, 2 * CTS_LF_DIV);
    wr(CTS_OFF_HIGH_CTRL, 8'h57, CTS_RESP_OKAY);
    $display("test clock sources done");
  endtask

  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    test_reset();
    test_regs();
    test_ppg(1'b0);
    test_ppg(1'b1);
    test_hold();
    test_warm();
    test_ext();
    test_clk();
    report_and_stop();
  end
endmodule
`default_nettype wire
